/* include/gpib_pkg.sv */
// shared constants and types for both ends of the instrument bus port
// assumes a single 20 MHz clock at each end; bus lines are active low
package gpib_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC - 1);

  // ----------------------------------------
  // management and handshake line positions
  // ----------------------------------------
  localparam int L_DAV = 0;
  localparam int L_NRFD = 1;
  localparam int L_NDAC = 2;
  localparam int L_EOI = 3;
  localparam int L_ATN = 4;
  localparam int L_IFC = 5;
  localparam int L_REN = 6;
  localparam int L_SRQ = 7;
  localparam logic [14:0] SYNC_IDLE = 15'h7fff;

  // ----------------------------------------
  // interface message codes (seven bits)
  // ----------------------------------------
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [1:0] LAD_GRP = 2'h1;
  localparam logic [1:0] TAD_GRP = 2'h2;
  localparam logic [1:0] SAD_GRP = 2'h3;
  localparam logic [4:0] UN_ADDR = 5'h1f;
  localparam int RQS_BIT = 6;

  typedef enum logic [3:0] {C_NONE, C_MLA, C_UNL, C_MTA, C_UNT, C_OTA, C_DCL, C_SDC, C_GTL, C_SPE, C_SPD,
                            C_SEC} cmd_t;
  typedef enum logic [1:0] {A_IDLE, A_READY, A_TAKE, A_DONE} acc_t;
  typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_DAV, S_RELEASE} src_t;

  // classify a byte received with attention true
  function automatic cmd_t decode_cmd(input logic [6:0] b, input logic [4:0] a);
    cmd_t c;
    c = C_NONE;
    case (b[6:5])
      LAD_GRP: c = (b[4:0] == UN_ADDR) ? C_UNL : ((b[4:0] == a) ? C_MLA : C_NONE);
      TAD_GRP: c = (b[4:0] == UN_ADDR) ? C_UNT : ((b[4:0] == a) ? C_MTA : C_OTA);
      SAD_GRP: c = C_SEC;
      default: begin
        case (b)
          CMD_GTL: c = C_GTL;
          CMD_SDC: c = C_SDC;
          CMD_DCL: c = C_DCL;
          CMD_SPE: c = C_SPE;
          CMD_SPD: c = C_SPD;
          default: c = C_NONE;
        endcase
      end
    endcase
    return c;
  endfunction : decode_cmd
endpackage : gpib_pkg

/* include/gpib_if.sv */
// bus carrier joining the instrument end and the controller end
// every line is open drain: low level means true; the wire is the wired-or of all drivers
`timescale 1ns/100ps
interface gpib_if;
  logic [7:0] dev_dio_o;
  logic [7:0] dev_dio_oe;
  logic [7:0] dev_mgmt_o;
  logic [7:0] dev_mgmt_oe;
  logic [7:0] ctl_dio_o;
  logic [7:0] ctl_dio_oe;
  logic [7:0] ctl_mgmt_o;
  logic [7:0] ctl_mgmt_oe;
  logic [7:0] dio_i;
  logic [7:0] mgmt_i;

  // wired-or resolution: any enabled driver at low pulls the line low
  assign dio_i = ~((dev_dio_oe & ~dev_dio_o) | (ctl_dio_oe & ~ctl_dio_o));
  assign mgmt_i = ~((dev_mgmt_oe & ~dev_mgmt_o) | (ctl_mgmt_oe & ~ctl_mgmt_o));

  modport device (output dev_dio_o, dev_dio_oe, dev_mgmt_o, dev_mgmt_oe, input dio_i, mgmt_i);
  modport controller (output ctl_dio_o, ctl_dio_oe, ctl_mgmt_o, ctl_mgmt_oe, input dio_i, mgmt_i);
endinterface : gpib_if

/* rtl/instrument_port.sv */
// instrument end of the byte-parallel instrument bus: addressing, remote state,
// service request, acceptor and source handshakes, two-entry receive buffer
// assumes the bus lines arrive asynchronously and are resolved by gpib_if
//
// What this block does
// - eight active-low data lines, one byte per handshake
// - first data line is lsb, eighth is msb
// - seven-bit messages, top bit ignored; data bytes keep all eight bits
// - received byte is address, control or data
// - attention true: decode messages and own addresses
// - end line true only with final byte
// - end with attention means poll, not end; no poll response here
// - interface clear unaddresses and idles service request
// - remote enable plus listen address enters remote
// - leave remote on enable low, gtl, local
// - service request only in interrupt mode
// - data valid after ready, data, settle
// - listener holds not-ready until byte accepted
// - listener releases not-accepted once byte taken
// - wired-or lines wait for slowest listener
// - talker drops data valid after accepted seen
// - listener reasserts not-accepted after data valid drops
// - listener releases not-ready when processing done
`timescale 1ns/100ps
module instrument_port
  import gpib_pkg::*;
(
  input logic clk,
  input logic rst_n,
  gpib_if.device bus,
  input logic [4:0] my_addr,
  input logic interrupt_mode,
  input logic service_req,
  input logic return_to_local_command,
  input logic [7:0] status_byte,
  input logic [7:0] tx_data,
  input logic tx_end,
  input logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_valid,
  input logic rx_ready,
  output logic remote,
  output logic listen_active,
  output logic talk_active,
  output logic spoll_active,
  output logic srq_pending,
  output logic dev_clear
);
  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  logic [14:0] meta_r;
  logic [14:0] sync_r;
  logic [14:0] line_t;
  logic [7:0] dio_t;
  logic dav_t, nrfd_t, ndac_t, eoi_t, atn_t, ifc_t, ren_t;

  // two stages; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= SYNC_IDLE;
      sync_r <= SYNC_IDLE;
    end else begin
      meta_r <= {bus.mgmt_i[L_REN:0], bus.dio_i};
      sync_r <= meta_r;
    end
  end

  // low level is true on every line
  assign line_t = ~sync_r;
  assign dio_t = line_t[7:0];
  assign dav_t = line_t[8 + L_DAV];
  assign nrfd_t = line_t[8 + L_NRFD];
  assign ndac_t = line_t[8 + L_NDAC];
  assign eoi_t = line_t[8 + L_EOI];
  assign atn_t = line_t[8 + L_ATN];
  assign ifc_t = line_t[8 + L_IFC];
  assign ren_t = line_t[8 + L_REN];

  // ----------------------------------------
  // acceptor and addressing state
  // ----------------------------------------
  acc_t acc_r, acc_nxt;
  logic [7:0] cap_r, cap_nxt;
  logic cap_eoi_r, cap_eoi_nxt, cap_atn_r, cap_atn_nxt;
  logic listen_r, listen_nxt, talk_r, talk_nxt, spoll_r, spoll_nxt;
  logic remote_r, remote_nxt, clr_r, clr_nxt;
  logic part, can_accept, fifo_full;
  cmd_t cmd;

  // every device takes part while attention is true; data only when addressed
  assign part = atn_t | listen_r;
  assign can_accept = atn_t | ~fifo_full;
  assign cmd = decode_cmd(cap_r[6:0], my_addr);

  // acceptor handshake and message decode
  always_comb begin
    acc_nxt = acc_r;
    cap_nxt = cap_r;
    cap_eoi_nxt = cap_eoi_r;
    cap_atn_nxt = cap_atn_r;
    listen_nxt = listen_r;
    talk_nxt = talk_r;
    spoll_nxt = spoll_r;
    remote_nxt = remote_r;
    clr_nxt = 1'b0;
    case (acc_r)
      A_IDLE: begin
        // our own aborted data valid still echoes through the synchroniser; never take it as a message
        if (part && !dav_t) acc_nxt = A_READY;
      end
      A_READY: begin
        if (!part) begin
          acc_nxt = A_IDLE;
        end else if (dav_t && can_accept) begin
          acc_nxt = A_TAKE;
          cap_nxt = dio_t;
          cap_eoi_nxt = eoi_t;
          cap_atn_nxt = atn_t;
        end
      end
      A_TAKE: begin
        acc_nxt = A_DONE;
        if (cap_atn_r) begin
          case (cmd)
            C_MLA: begin
              listen_nxt = 1'b1;
              if (ren_t) remote_nxt = 1'b1;
            end
            C_UNL: listen_nxt = 1'b0;
            C_MTA: talk_nxt = 1'b1;
            C_UNT, C_OTA: talk_nxt = 1'b0;
            C_DCL: clr_nxt = 1'b1;
            C_SDC: clr_nxt = listen_r;
            C_GTL: begin
              if (listen_r) remote_nxt = 1'b0;
            end
            C_SPE: spoll_nxt = 1'b1;
            C_SPD: spoll_nxt = 1'b0;
            default: ;
          endcase
        end
      end
      A_DONE: begin
        if (!dav_t) acc_nxt = part ? A_READY : A_IDLE;
      end
      default: acc_nxt = A_IDLE;
    endcase
    if (!ren_t || return_to_local_command) remote_nxt = 1'b0;
    if (ifc_t) begin
      listen_nxt = 1'b0;
      talk_nxt = 1'b0;
      spoll_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= A_IDLE;
      cap_r <= 8'h00;
      cap_eoi_r <= 1'b0;
      cap_atn_r <= 1'b0;
      listen_r <= 1'b0;
      talk_r <= 1'b0;
      spoll_r <= 1'b0;
      remote_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      cap_r <= cap_nxt;
      cap_eoi_r <= cap_eoi_nxt;
      cap_atn_r <= cap_atn_nxt;
      listen_r <= listen_nxt;
      talk_r <= talk_nxt;
      spoll_r <= spoll_nxt;
      remote_r <= remote_nxt;
      clr_r <= clr_nxt;
    end
  end

  // ----------------------------------------
  // two-entry receive buffer
  // ----------------------------------------
  logic [8:0] buf_r [0:1];
  logic [8:0] buf_nxt [0:1];
  logic wr_r, wr_nxt, rd_r, rd_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  // bytes taken under attention are messages and never reach the user
  assign push = (acc_r == A_TAKE) && !cap_atn_r;
  assign pop = rx_valid && rx_ready;
  assign fifo_full = (cnt_r == 2'd2);

  // a full buffer keeps not-ready held, so a stalled user loses nothing
  always_comb begin
    buf_nxt = buf_r;
    if (push) buf_nxt[wr_r] = {cap_eoi_r, cap_r};
    wr_nxt = wr_r ^ push;
    rd_nxt = rd_r ^ pop;
    cnt_nxt = cnt_r + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) buf_r[i] <= 9'h000;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      buf_r <= buf_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // source handshake and service request
  // ----------------------------------------
  src_t src_r, src_nxt;
  logic [3:0] set_r, set_nxt;
  logic [7:0] dio_oe_r, dio_oe_nxt;
  logic eoi_r, eoi_nxt, srq_r, srq_nxt;
  logic talk_en, start;
  logic [7:0] stat;

  assign talk_en = talk_r && !atn_t;
  assign start = (src_r == S_IDLE) && talk_en && (spoll_r || tx_valid) && !nrfd_t;

  // status byte carries the pending request in its rqs bit
  always_comb begin
    stat = status_byte;
    stat[RQS_BIT] = srq_r;
    src_nxt = src_r;
    set_nxt = set_r;
    dio_oe_nxt = dio_oe_r;
    eoi_nxt = eoi_r;
    srq_nxt = srq_r;
    case (src_r)
      S_IDLE: begin
        if (start) begin
          dio_oe_nxt = spoll_r ? stat : tx_data;
          eoi_nxt = !spoll_r && tx_end;
          set_nxt = SETTLE_CNT;
          src_nxt = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (set_r == 4'h0) src_nxt = S_DAV;
        else set_nxt = set_r - 4'h1;
      end
      S_DAV: begin
        if (!ndac_t) begin
          src_nxt = S_RELEASE;
          dio_oe_nxt = 8'h00;
          eoi_nxt = 1'b0;
          if (spoll_r && dio_oe_r[RQS_BIT]) srq_nxt = 1'b0;
        end
      end
      S_RELEASE: src_nxt = S_IDLE;
      default: src_nxt = S_IDLE;
    endcase
    // attention or unaddressing ends a transfer at once; the byte is dropped
    if (!talk_en && src_r != S_IDLE) begin
      src_nxt = S_IDLE;
      dio_oe_nxt = 8'h00;
      eoi_nxt = 1'b0;
    end
    if (ifc_t || clr_r) srq_nxt = 1'b0;
    if (service_req && interrupt_mode) srq_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= S_IDLE;
      set_r <= 4'h0;
      dio_oe_r <= 8'h00;
      eoi_r <= 1'b0;
      srq_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      set_r <= set_nxt;
      dio_oe_r <= dio_oe_nxt;
      eoi_r <= eoi_nxt;
      srq_r <= srq_nxt;
    end
  end

  // ----------------------------------------
  // pins and user outputs
  // ----------------------------------------
  // drivers only ever pull low; attention, clear and remote enable are never driven here
  always_comb begin
    bus.dev_mgmt_oe = 8'h00;
    bus.dev_mgmt_oe[L_DAV] = (src_r == S_DAV);
    bus.dev_mgmt_oe[L_NRFD] = ((acc_r == A_READY) && !can_accept) || (acc_r == A_TAKE) || (acc_r == A_DONE);
    bus.dev_mgmt_oe[L_NDAC] = (acc_r == A_READY) || (acc_r == A_TAKE);
    bus.dev_mgmt_oe[L_EOI] = eoi_r && (src_r == S_SETTLE || src_r == S_DAV);
    bus.dev_mgmt_oe[L_SRQ] = srq_r && interrupt_mode;
  end
  assign bus.dev_mgmt_o = 8'h00;
  assign bus.dev_dio_o = 8'h00;
  assign bus.dev_dio_oe = dio_oe_r;
  assign tx_ready = start && !spoll_r;
  assign rx_valid = (cnt_r != 2'd0);
  assign rx_data = buf_r[rd_r][7:0];
  assign rx_end = buf_r[rd_r][8];
  assign remote = remote_r;
  assign listen_active = listen_r;
  assign talk_active = talk_r;
  assign spoll_active = spoll_r;
  assign srq_pending = srq_r;
  assign dev_clear = clr_r;
endmodule : instrument_port

/* rtl/bus_controller.sv */
// controller end of the instrument bus: sends commands and data as source,
// takes data as acceptor, drives attention, interface clear and remote enable
// assumes bus lines are synchronous to clk (same clock as the far end)
`timescale 1ns/100ps
module bus_controller
  import gpib_pkg::*;
(
  input logic clk,
  input logic rst_n,
  gpib_if.controller bus,
  input logic [7:0] cmd_data,
  input logic cmd_atn,
  input logic cmd_end,
  input logic cmd_valid,
  output logic cmd_ready,
  input logic listen_en,
  output logic [7:0] rd_data,
  output logic rd_end,
  output logic rd_valid,
  input logic ifc_req,
  input logic ren_req,
  output logic srq_seen
);
  // ----------------------------------------
  // line decode
  // ----------------------------------------
  logic [7:0] dio_t;
  logic dav_t, nrfd_t, ndac_t, eoi_t;

  assign dio_t = ~bus.dio_i;
  assign dav_t = ~bus.mgmt_i[L_DAV];
  assign nrfd_t = ~bus.mgmt_i[L_NRFD];
  assign ndac_t = ~bus.mgmt_i[L_NDAC];
  assign eoi_t = ~bus.mgmt_i[L_EOI];

  // ----------------------------------------
  // source, attention and acceptor
  // ----------------------------------------
  src_t src_r, src_nxt;
  acc_t acc_r, acc_nxt;
  logic [3:0] set_r, set_nxt;
  logic [7:0] dio_oe_r, dio_oe_nxt, rd_data_r, rd_data_nxt;
  logic eoi_r, eoi_nxt, atn_r, atn_nxt, rd_end_r, rd_end_nxt, rd_valid_r, rd_valid_nxt;
  logic srq_r;
  logic acc_on, start;

  assign acc_on = listen_en && !atn_r;
  // attention must already match before the byte goes out
  assign start = (src_r == S_IDLE) && cmd_valid && (cmd_atn == atn_r) && !nrfd_t && !dav_t;

  always_comb begin
    src_nxt = src_r;
    acc_nxt = acc_r;
    set_nxt = set_r;
    dio_oe_nxt = dio_oe_r;
    eoi_nxt = eoi_r;
    atn_nxt = atn_r;
    rd_data_nxt = rd_data_r;
    rd_end_nxt = rd_end_r;
    rd_valid_nxt = 1'b0;
    case (src_r)
      S_IDLE: begin
        if (start) begin
          dio_oe_nxt = cmd_data;
          eoi_nxt = cmd_end && !cmd_atn;
          set_nxt = SETTLE_CNT;
          src_nxt = S_SETTLE;
        end else if (cmd_valid && cmd_atn != atn_r && acc_r != A_DONE) begin
          atn_nxt = cmd_atn;
        end else if (!cmd_valid && listen_en && atn_r) begin
          atn_nxt = 1'b0;
        end
      end
      S_SETTLE: begin
        if (set_r == 4'h0) src_nxt = S_DAV;
        else set_nxt = set_r - 4'h1;
      end
      S_DAV: begin
        if (!ndac_t) begin
          src_nxt = S_RELEASE;
          dio_oe_nxt = 8'h00;
          eoi_nxt = 1'b0;
        end
      end
      S_RELEASE: src_nxt = S_IDLE;
      default: src_nxt = S_IDLE;
    endcase
    // acceptor has no buffer, so it is ready again as soon as data valid drops
    case (acc_r)
      A_IDLE: begin
        if (acc_on) acc_nxt = A_READY;
      end
      A_READY: begin
        if (!acc_on) begin
          acc_nxt = A_IDLE;
        end else if (dav_t) begin
          rd_data_nxt = dio_t;
          rd_end_nxt = eoi_t;
          rd_valid_nxt = 1'b1;
          acc_nxt = A_DONE;
        end
      end
      A_DONE: begin
        if (!dav_t) acc_nxt = acc_on ? A_READY : A_IDLE;
      end
      default: acc_nxt = A_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= S_IDLE;
      acc_r <= A_IDLE;
      set_r <= 4'h0;
      dio_oe_r <= 8'h00;
      eoi_r <= 1'b0;
      atn_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_end_r <= 1'b0;
      rd_valid_r <= 1'b0;
      srq_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      acc_r <= acc_nxt;
      set_r <= set_nxt;
      dio_oe_r <= dio_oe_nxt;
      eoi_r <= eoi_nxt;
      atn_r <= atn_nxt;
      rd_data_r <= rd_data_nxt;
      rd_end_r <= rd_end_nxt;
      rd_valid_r <= rd_valid_nxt;
      srq_r <= ~bus.mgmt_i[L_SRQ];
    end
  end

  // ----------------------------------------
  // pins and user outputs
  // ----------------------------------------
  always_comb begin
    bus.ctl_mgmt_oe = 8'h00;
    bus.ctl_mgmt_oe[L_DAV] = (src_r == S_DAV);
    bus.ctl_mgmt_oe[L_NRFD] = (acc_r == A_DONE);
    bus.ctl_mgmt_oe[L_NDAC] = (acc_r == A_READY);
    bus.ctl_mgmt_oe[L_EOI] = eoi_r && (src_r == S_SETTLE || src_r == S_DAV);
    bus.ctl_mgmt_oe[L_ATN] = atn_r;
    bus.ctl_mgmt_oe[L_IFC] = ifc_req;
    bus.ctl_mgmt_oe[L_REN] = ren_req;
  end
  assign bus.ctl_mgmt_o = 8'h00;
  assign bus.ctl_dio_o = 8'h00;
  assign bus.ctl_dio_oe = dio_oe_r;
  assign cmd_ready = start;
  assign rd_data = rd_data_r;
  assign rd_end = rd_end_r;
  assign rd_valid = rd_valid_r;
  assign srq_seen = srq_r;
endmodule : bus_controller

/* bench/instrument_bus_checker.sv */
// checker for the shared bus wire: settle, data hold, eoi framing, handshake order
// assumes both ends share clk and rst_n; takes the gpib_if signals as inputs
`timescale 1ns/100ps
module instrument_bus_checker
  import gpib_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic [7:0] dev_dio_oe,
  input logic [7:0] dev_mgmt_oe,
  input logic [7:0] ctl_dio_oe,
  input logic [7:0] ctl_mgmt_oe,
  input logic [7:0] mgmt_i
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence ctl_dav_up;
    $rose(ctl_mgmt_oe[L_DAV]);
  endsequence
  sequence dev_dav_up;
    $rose(dev_mgmt_oe[L_DAV]);
  endsequence
  sequence ifc_held;
    $fell(mgmt_i[L_IFC]) ##1 !mgmt_i[L_IFC] [*5];
  endsequence

  // ----------------------------------------
  // source side
  // ----------------------------------------
  // data must already stand for the settle count before valid is shown
  a_ctl_settle_wait: assert property (ctl_dav_up |-> ctl_dio_oe == $past(ctl_dio_oe, 9))
    else $error("controller data moved during settle");
  a_dev_settle_wait: assert property (dev_dav_up |-> dev_dio_oe == $past(dev_dio_oe, 9))
    else $error("instrument data moved during settle");
  a_data_holds: assert property ($past(ctl_mgmt_oe[L_DAV]) && ctl_mgmt_oe[L_DAV] |-> $stable(ctl_dio_oe))
    else $error("controller data changed while valid");
  a_eoi_not_atn: assert property (ctl_mgmt_oe[L_EOI] |-> !ctl_mgmt_oe[L_ATN])
    else $error("end marker sent under attention");
  a_ctl_dav_drop: assert property (ctl_mgmt_oe[L_DAV] && mgmt_i[L_NDAC] |-> ##[1:3] !ctl_mgmt_oe[L_DAV])
    else $error("controller kept valid after acceptance");
  a_dev_dav_drop: assert property (dev_mgmt_oe[L_DAV] && mgmt_i[L_NDAC] |-> ##[1:4] !dev_mgmt_oe[L_DAV])
    else $error("instrument kept valid after acceptance");

  // ----------------------------------------
  // acceptor side
  // ----------------------------------------
  a_dev_hold_rfd: assert property ($fell(dev_mgmt_oe[L_NDAC]) && !mgmt_i[L_DAV] |-> dev_mgmt_oe[L_NRFD])
    else $error("instrument freed ready before taking byte");
  a_dev_ndac_free: assert property ($fell(mgmt_i[L_DAV]) && dev_mgmt_oe[L_NDAC] |-> ##[1:5] !dev_mgmt_oe[L_NDAC])
    else $error("instrument never accepted byte");
  a_ctl_ndac_back: assert property ($rose(mgmt_i[L_DAV]) && ctl_mgmt_oe[L_NRFD] |-> ##[0:3] ctl_mgmt_oe[L_NDAC])
    else $error("controller did not reassert not-accepted");
  a_ctl_rfd_free: assert property ($rose(ctl_mgmt_oe[L_NDAC]) |-> ##[0:3] !ctl_mgmt_oe[L_NRFD])
    else $error("controller never became ready");
  // a held clear must leave the instrument silent: no valid, no service request
  a_ifc_quiets: assert property (ifc_held |-> !dev_mgmt_oe[L_DAV] && !dev_mgmt_oe[L_SRQ])
    else $error("instrument active after interface clear");
endmodule : instrument_bus_checker

/* bench/test_instrument_bus_interface.sv */
// self-checking bench: instrument end and controller end joined by gpib_if
// assumes one shared 20 MHz clock; expectations come from bench functions
`timescale 1ns/100ps
module test_instrument_bus_interface;
  import gpib_pkg::*;
  logic clk, rst_n, interrupt_mode, service_req, return_to_local_command, tx_end, tx_valid, tx_ready;
  logic rx_end, rx_valid, rx_ready, remote, listen_active, talk_active, spoll_active, srq_pending, dev_clear;
  logic cmd_atn, cmd_end, cmd_valid, cmd_ready, listen_en, rd_end, rd_valid, ifc_req, ren_req, srq_seen, stall;
  logic dav_prev;
  logic [4:0] my_addr;
  logic [7:0] status_byte, tx_data, rx_data, cmd_data, rd_data;
  logic [8:0] rx_q[$], rd_q[$];
  logic [7:0] wire_q[$], sent[$];
  int err_count, check_count, clr_count, i, k;

  gpib_if bus_if();
  instrument_port u_instrument_port(.clk, .rst_n, .bus(bus_if), .my_addr, .interrupt_mode, .service_req,
    .return_to_local_command, .status_byte, .tx_data, .tx_end, .tx_valid, .tx_ready, .rx_data, .rx_end,
    .rx_valid, .rx_ready, .remote, .listen_active, .talk_active, .spoll_active, .srq_pending, .dev_clear);
  bus_controller u_bus_controller(.clk, .rst_n, .bus(bus_if), .cmd_data, .cmd_atn, .cmd_end, .cmd_valid,
    .cmd_ready, .listen_en, .rd_data, .rd_end, .rd_valid, .ifc_req, .ren_req, .srq_seen);
  instrument_bus_checker u_checker(.clk, .rst_n, .dev_dio_oe(bus_if.dev_dio_oe), .dev_mgmt_oe(bus_if.dev_mgmt_oe),
    .ctl_dio_oe(bus_if.ctl_dio_oe), .ctl_mgmt_oe(bus_if.ctl_mgmt_oe), .mgmt_i(bus_if.mgmt_i));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // hold the request until ready is seen, release on the taking edge
  task automatic take(ref logic rdy);
    int n;
    for (n = 0; n < 6000 && rdy !== 1'b1; n++) @(negedge clk);
    if (rdy !== 1'b1) chk(9'h000, 9'h001);
    @(posedge clk);
  endtask : take

  task automatic send(input logic [7:0] d, input logic atn, input logic e);
    @(posedge clk);
    cmd_data <= d;
    cmd_atn <= atn;
    cmd_end <= e;
    cmd_valid <= 1'b1;
    take(cmd_ready);
    cmd_valid <= 1'b0;
  endtask : send

  task automatic tx(input logic [7:0] d, input logic e);
    @(posedge clk);
    tx_data <= d;
    tx_end <= e;
    tx_valid <= 1'b1;
    take(tx_ready);
    tx_valid <= 1'b0;
  endtask : tx

  // bus idle long enough for the instrument's late view to catch up
  task automatic quiet();
    int n;
    int m;
    n = 0;
    for (m = 0; m < 4000 && n < 12; m++) begin
      @(negedge clk);
      n = (bus_if.mgmt_i[L_DAV] && !cmd_valid && !tx_valid) ? n + 1 : 0;
    end
    chk(9'(n), 9'h00c);
  endtask : quiet

  function automatic logic [8:0] exp_rx(input logic [7:0] d, input logic last);
    return {last, 1'b0, d[6:0]};
  endfunction : exp_rx

  function automatic logic [7:0] addr_byte(input logic [1:0] grp, input logic [4:0] a);
    return {1'b0, grp, a};
  endfunction : addr_byte

  // monitors sample at the falling edge where everything has settled
  always @(negedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back({rx_end, rx_data});
    if (rd_valid === 1'b1) rd_q.push_back({rd_end, rd_data});
    if (dev_clear === 1'b1) clr_count++;
    if (dav_prev === 1'b1 && bus_if.mgmt_i[L_DAV] === 1'b0) wire_q.push_back(~bus_if.dio_i);
    dav_prev <= bus_if.mgmt_i[L_DAV];
  end

  // a slow, randomly stalling reader behind the receive buffer
  always @(posedge clk) rx_ready <= !stall && ($urandom % 4 != 0);

  initial begin
    #3000000;
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    i = $urandom(32'h84fead9e);
    {rst_n, interrupt_mode, service_req, return_to_local_command, tx_end, tx_valid} = '0;
    {cmd_atn, cmd_end, cmd_valid, listen_en, ifc_req, ren_req, stall} = '0;
    {status_byte, tx_data, cmd_data} = '0;
    my_addr = 5'($urandom % 31);
    repeat (3) @(posedge clk);
    chk(9'(bus_if.dev_mgmt_oe | bus_if.ctl_mgmt_oe | bus_if.ctl_dio_oe), 9'h000);
    rst_n <= 1'b1;
    ren_req <= 1'b1;
    send(addr_byte(LAD_GRP, my_addr), 1'b1, 1'b0);
    quiet();
    chk({listen_active, remote}, 9'h003);
    $display("test address done");
    wire_q.delete();
    stall <= 1'b1;
    fork
      for (i = 0; i < 6; i++) begin
        sent.push_back(8'($urandom));
        send(sent[i], 1'b0, i == 5);
      end
      begin
        repeat (250) @(negedge clk);
        chk({bus_if.mgmt_i[L_NRFD], rx_valid, 7'(rx_q.size())}, 9'h080);
        stall <= 1'b0;
      end
    join
    quiet();
    chk(9'(rx_q.size()), 9'h006);
    for (i = 0; i < 6; i++) begin
      chk({rx_q[i][8], 1'b0, rx_q[i][6:0]}, exp_rx(sent[i], i == 5));
      chk(9'(wire_q[i]), 9'(sent[i]));
    end
    $display("test receive done");
    send(8'h3f, 1'b1, 1'b1);
    send(addr_byte(TAD_GRP, my_addr), 1'b1, 1'b0);
    listen_en <= 1'b1;
    quiet();
    chk({talk_active, listen_active}, 9'h002);
    sent.delete();
    for (i = 0; i < 4; i++) begin
      sent.push_back(8'($urandom));
      tx(sent[i], i == 3);
    end
    quiet();
    chk(9'(rd_q.size()), 9'h004);
    for (i = 0; i < 4; i++) chk({rd_q[i][8], 1'b0, rd_q[i][6:0]}, exp_rx(sent[i], i == 3));
    listen_en <= 1'b0;
    send(8'h5f, 1'b1, 1'b0);
    quiet();
    chk(9'(talk_active), 9'h000);
    $display("test talk done");
    send(addr_byte(LAD_GRP, my_addr), 1'b1, 1'b0);
    service_req <= 1'b1;
    @(posedge clk);
    service_req <= 1'b0;
    repeat (4) @(negedge clk);
    chk({srq_pending, bus_if.mgmt_i[L_SRQ]}, 9'h001);
    @(posedge clk);
    interrupt_mode <= 1'b1;
    service_req <= 1'b1;
    @(posedge clk);
    service_req <= 1'b0;
    repeat (4) @(negedge clk);
    chk({srq_seen, bus_if.mgmt_i[L_SRQ]}, 9'h002);
    quiet();
    @(posedge clk);
    ifc_req <= 1'b1;
    repeat (10) @(posedge clk);
    ifc_req <= 1'b0;
    repeat (4) @(negedge clk);
    chk({listen_active, talk_active, srq_pending, bus_if.mgmt_i[L_SRQ]}, 9'h001);
    // serial poll: first status byte carries the pending request, its acceptance clears it
    status_byte <= 8'($urandom);
    service_req <= 1'b1;
    send(CMD_SPE, 1'b1, 1'b0);
    service_req <= 1'b0;
    send(addr_byte(TAD_GRP, my_addr), 1'b1, 1'b0);
    rd_q.delete();
    listen_en <= 1'b1;
    repeat (100) @(negedge clk);
    send(CMD_SPD, 1'b1, 1'b0);
    listen_en <= 1'b0;
    quiet();
    chk(rd_q[0], {1'b0, status_byte | 8'h40});
    chk(rd_q[1], {1'b0, status_byte & 8'hbf});
    chk({spoll_active, srq_pending}, 9'h000);
    $display("test service and clear done");
    for (k = 0; k < 3; k++) begin
      send(addr_byte(LAD_GRP, my_addr), 1'b1, 1'b0);
      quiet();
      chk(9'(remote), 9'h001);
      @(posedge clk);
      if (k == 0) ren_req <= 1'b0;
      else if (k == 1) send(CMD_GTL, 1'b1, 1'b0);
      else return_to_local_command <= 1'b1;
      @(posedge clk);
      return_to_local_command <= 1'b0;
      quiet();
      chk(9'(remote), 9'h000);
      ren_req <= 1'b1;
    end
    ren_req <= 1'b0;
    send(addr_byte(LAD_GRP, my_addr), 1'b1, 1'b0);
    send(CMD_SDC, 1'b1, 1'b0);
    send(CMD_DCL, 1'b1, 1'b0);
    quiet();
    chk({remote, 8'(clr_count)}, 9'h002);
    $display("test remote and clear done");
    report_and_stop();
  end
endmodule : test_instrument_bus_interface
